// [logic/lasl_alarm_status.sv]
`timescale 1ns/1ps
`default_nettype none
module lasl_alarm_status #(
  parameter int HOLD_CYCLES = lasl_pkg::HOLD_CYCLES,
  parameter int PTR_W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Host register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Detector inputs
  input wire logic driver_fault_in,
  input wire logic [PTR_W-1:0] fifo_wr_ptr,
  input wire logic [PTR_W-1:0] fifo_rd_ptr,
  input wire logic line_code_violation,
  input wire logic excess_zeros,
  input wire logic zero_subst_en,
  input wire logic all_ones_in,
  // Receive data
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // Loop-code mode select
  input wire logic loop_code_mode_hi,
  input wire logic loop_code_mode_lo,
  // Outputs
  output logic remote_loopback,
  output logic int_n
);

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LIMIT = CNT_W'(HOLD_CYCLES);
  localparam logic [PTR_W-1:0] NEAR_LIMIT = PTR_W'(lasl_pkg::FIFO_NEAR_BITS);

  typedef struct packed {
    logic [7:0] alarm;
    logic [7:0] irq_en;
    logic [7:0] irq_stat;
    logic [7:0] rdata;
    logic [lasl_pkg::LOOP_UP_LEN-1:0] hist_up;
    logic [lasl_pkg::LOOP_DOWN_LEN-1:0] hist_down;
    logic [CNT_W-1:0] up_cnt;
    logic [CNT_W-1:0] down_cnt;
    lasl_pkg::lasl_mode_t mode;
    lasl_pkg::lasl_auto_t auto_st;
    logic loopback;
    logic int_n;
  } lasl_state_t;

  lasl_state_t s;
  lasl_state_t next_s;

  logic [PTR_W-1:0] ptr_diff;
  logic up_ok;
  logic down_ok;
  logic up_held;
  logic down_held;
  logic restart;
  logic loop_flag;
  logic [7:0] change;
  lasl_pkg::lasl_mode_t mode_now;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    restart = 1'b0;
    loop_flag = 1'b0;
    mode_now = lasl_pkg::lasl_mode_t'({loop_code_mode_hi, loop_code_mode_lo});
    ptr_diff = fifo_wr_ptr - fifo_rd_ptr;

    // A sliding window holding exactly one 1 at every shift means the
    // code repeats with its own period; any other bit breaks it.
    if (rx_bit_valid) begin
      next_s.hist_up = {s.hist_up[lasl_pkg::LOOP_UP_LEN-2:0], rx_bit};
      next_s.hist_down = {s.hist_down[lasl_pkg::LOOP_DOWN_LEN-2:0], rx_bit};
    end
    up_ok = $onehot(s.hist_up);
    down_ok = $onehot(s.hist_down);
    up_held = s.up_cnt == HOLD_LIMIT;
    down_held = s.down_cnt == HOLD_LIMIT;

    // Loop-code detector
    next_s.mode = mode_now;
    case (mode_now)
      lasl_pkg::MODE_MANUAL_A, lasl_pkg::MODE_MANUAL_B: begin
        loop_flag = up_held | down_held;
        next_s.loopback = 1'b0;
        next_s.auto_st = lasl_pkg::AUTO_SEEK_UP;
      end
      lasl_pkg::MODE_AUTO: begin
        if (s.mode != lasl_pkg::MODE_AUTO) begin
          loop_flag = 1'b0;
          next_s.loopback = 1'b0;
          next_s.auto_st = lasl_pkg::AUTO_SEEK_UP;
          restart = 1'b1;
        end else begin
          case (s.auto_st)
            lasl_pkg::AUTO_SEEK_UP: begin
              if (up_held) begin
                loop_flag = 1'b1;
                next_s.loopback = 1'b1;
                next_s.auto_st = lasl_pkg::AUTO_LOOPED;
                restart = 1'b1;
              end
            end
            lasl_pkg::AUTO_LOOPED: begin
              loop_flag = 1'b1;
              if (down_held) begin
                loop_flag = 1'b0;
                next_s.loopback = 1'b0;
                next_s.auto_st = lasl_pkg::AUTO_SEEK_UP;
                restart = 1'b1;
              end
            end
            default: begin
              next_s.auto_st = lasl_pkg::AUTO_SEEK_UP;
            end
          endcase
        end
      end
      default: begin
        next_s.loopback = 1'b0;
        next_s.auto_st = lasl_pkg::AUTO_SEEK_UP;
      end
    endcase

    // Persistence timers; saturate so the held level stays while present
    if (!up_ok || restart) begin
      next_s.up_cnt = '0;
    end else if (!up_held) begin
      next_s.up_cnt = s.up_cnt + 1'b1;
    end
    if (!down_ok || restart) begin
      next_s.down_cnt = '0;
    end else if (!down_held) begin
      next_s.down_cnt = s.down_cnt + 1'b1;
    end

    // Present-state alarm flags
    next_s.alarm = lasl_pkg::RESET_VALUE;
    next_s.alarm[lasl_pkg::BIT_DRIVER] = driver_fault_in;
    next_s.alarm[lasl_pkg::BIT_FIFO] = (ptr_diff <= NEAR_LIMIT) || (ptr_diff >= -NEAR_LIMIT);
    next_s.alarm[lasl_pkg::BIT_LINE_CODE] = line_code_violation | (zero_subst_en & excess_zeros);
    next_s.alarm[lasl_pkg::BIT_LOOP] = loop_flag;
    next_s.alarm[lasl_pkg::BIT_ALL_ONES] = all_ones_in;

    // Enable register write, then the hardware clear takes priority
    if (reg_wr && reg_addr == lasl_pkg::ADDR_IRQ_EN) begin
      next_s.irq_en = reg_wdata & lasl_pkg::IRQ_EN_MASK;
    end
    if (mode_now == lasl_pkg::MODE_AUTO && s.auto_st == lasl_pkg::AUTO_LOOPED && down_held) begin
      next_s.irq_en[lasl_pkg::BIT_LOOP] = 1'b0;
    end

    // Either edge of an enabled flag latches; set wins over read clear
    change = (next_s.alarm ^ s.alarm) & s.irq_en & lasl_pkg::ALARM_MASK;
    // Loop flag edges in both modes go through the same path.
    next_s.irq_stat = s.irq_stat;
    if (reg_rd && reg_addr == lasl_pkg::ADDR_IRQ_STAT) begin
      next_s.irq_stat = lasl_pkg::RESET_VALUE;
    end
    next_s.irq_stat = next_s.irq_stat | change;

    // Read data, held until the next read
    if (reg_rd) begin
      case (reg_addr)
        lasl_pkg::ADDR_IRQ_EN: next_s.rdata = s.irq_en;
        lasl_pkg::ADDR_ALARM: next_s.rdata = s.alarm;
        lasl_pkg::ADDR_IRQ_STAT: next_s.rdata = s.irq_stat;
        default: next_s.rdata = lasl_pkg::RESET_VALUE;
      endcase
    end

    next_s.int_n = !(next_s.irq_en[lasl_pkg::BIT_GLOBAL_EN] &&
                     |(next_s.irq_stat & next_s.irq_en & lasl_pkg::ALARM_MASK));
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.int_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign remote_loopback = s.loopback;
  assign int_n = s.int_n;

endmodule // lasl_alarm_status
`default_nettype wire

// [logic/lasl_pkg.sv]
`default_nettype none
package lasl_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_IRQ_EN = 5'h04;
  localparam logic [4:0] ADDR_ALARM = 5'h05;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h06;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ------------------------------------------------------------
  // Bit positions; 6 to 2 shared by status, enable and latched status, 7 in enable only
  // ------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_DRIVER = 6;
  localparam int BIT_FIFO = 5;
  localparam int BIT_LINE_CODE = 4;
  localparam int BIT_LOOP = 3;
  localparam int BIT_ALL_ONES = 2;
  localparam logic [7:0] ALARM_MASK = 8'h7c;
  localparam logic [7:0] IRQ_EN_MASK = 8'hfc;

  // ------------------------------------------------------------
  // Detector figures
  // ------------------------------------------------------------
  localparam int FIFO_NEAR_BITS = 3;
  localparam int LOOP_UP_LEN = 5;
  localparam int LOOP_DOWN_LEN = 3;
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int HOLD_TIME_S = 5;
  localparam int HOLD_CYCLES = SYS_CLK_HZ * HOLD_TIME_S;

  // ------------------------------------------------------------
  // Loop-code modes and automatic-mode states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_MANUAL_A = 2'b01,
    MODE_MANUAL_B = 2'b10,
    MODE_AUTO = 2'b11
  } lasl_mode_t;

  typedef enum logic {
    AUTO_SEEK_UP = 1'b0,
    AUTO_LOOPED = 1'b1
  } lasl_auto_t;

endpackage
`default_nettype wire

// [dv/lasl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lasl_assertions #(
  parameter int HOLD_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Host port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Detectors and outputs
  input wire logic driver_fault_in,
  input wire logic all_ones_in,
  input wire logic loop_code_mode_hi,
  input wire logic loop_code_mode_lo,
  input wire logic remote_loopback,
  input wire logic int_n
);
  // ------
  // Shadow of the enable register, loopback age
  // ------
  logic [7:0] en;
  int lb_cnt;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en <= 8'h00;
      lb_cnt <= 0;
    end else begin
      if (reg_wr && reg_addr == 5'h04) en <= reg_wdata;
      lb_cnt <= remote_loopback ? lb_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Read of the alarm location while x is steady
  sequence s_q(x); reg_rd && reg_addr == 5'h05 && $stable(x) && $past(resetn); endsequence
  sequence s_off; !en[7] ##1 !en[7]; endsequence
  property p_drv; s_q(driver_fault_in) |=> reg_rdata[6] == $past(driver_fault_in); endproperty
  a_drv: assert property (p_drv) else $error("driver bit wrong");
  property p_aio; s_q(all_ones_in) |=> reg_rdata[2] == $past(all_ones_in); endproperty
  a_aio: assert property (p_aio) else $error("all-ones bit wrong");
  property p_rsv; reg_rd && reg_addr == 5'h05 |=> reg_rdata[7] == 1'h0 && reg_rdata[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unm; reg_rd && !(reg_addr inside {[5'h04:5'h06]}) |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_gie; s_off |-> int_n; endproperty
  a_gie: assert property (p_gie) else $error("interrupt while masked");
  property p_lbm; !(loop_code_mode_hi && loop_code_mode_lo) |=> !remote_loopback; endproperty
  a_lbm: assert property (p_lbm) else $error("loopback outside auto");
  property p_lbh; $fell(remote_loopback) && $past(loop_code_mode_hi && loop_code_mode_lo) |->
    lb_cnt >= HOLD_CYCLES - 2; endproperty
  a_lbh: assert property (p_lbh) else $error("loopback released early");
  property p_drq; en[7] && en[6] && $changed(driver_fault_in) |-> ##[1:3] !int_n; endproperty
  a_drq: assert property (p_drq) else $error("no driver interrupt");
endmodule // lasl_assertions
`default_nettype wire

// [dv/lasl_host.sv]
`timescale 1ns/1ps
`default_nettype none
module lasl_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_rd = 1'h0,
  output logic reg_wr = 1'h0,
  output logic [4:0] reg_addr = 5'h1f,
  output logic [7:0] reg_wdata = 8'hff
);
  // ------
  // Host cycles, idle lines show the inverse
  // ------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'h0, ~a, ~d};
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'h1, a};
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'h0, ~a};
    d = reg_rdata;
  endtask
endmodule // lasl_host
`default_nettype wire

// [dv/test_line_alarm_status_loop_code.sv]
`timescale 1ns/1ps
`default_nettype none
module test_line_alarm_status_loop_code;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic reg_rd, reg_wr, driver_fault_in, line_code_violation, excess_zeros, zero_subst_en, all_ones_in;
  logic rx_bit_valid, rx_bit, loop_code_mode_hi, loop_code_mode_lo, remote_loopback, int_n;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, r, v;
  logic [5:0] fifo_wr_ptr, fifo_rd_ptr;
  int err_count = 0;
  int comparisons = 0;
  int d;
  lasl_alarm_status #(.HOLD_CYCLES(20)) DUT (.sys_clk, .resetn, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .driver_fault_in, .fifo_wr_ptr, .fifo_rd_ptr, .line_code_violation, .excess_zeros,
    .zero_subst_en, .all_ones_in, .rx_bit_valid, .rx_bit, .loop_code_mode_hi, .loop_code_mode_lo,
    .remote_loopback, .int_n);
  lasl_host h (.sys_clk, .reg_rdata, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);
  // ------
  // Helpers
  // ------
  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    #(100000 * 100);
    err_count++;
    tally_and_finish();
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    h.rd(a, v);
    chk(v, exp);
  endtask
  // Marker bit closes each len-bit group; a huge len sends zeros
  task automatic feed(input int len, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      {rx_bit_valid, rx_bit} = {1'h1, i % len == len - 1};
    end
    @(negedge sys_clk);
    {rx_bit_valid, rx_bit} = {1'h0, ~rx_bit};
  endtask
  task automatic quiet;
    {driver_fault_in, line_code_violation, excess_zeros, zero_subst_en, all_ones_in} = 5'h00;
    {fifo_wr_ptr, fifo_rd_ptr} = {6'h00, 6'h20};
  endtask
  initial begin
    quiet();
    {rx_bit_valid, rx_bit, loop_code_mode_hi, loop_code_mode_lo} = 4'h0;
    repeat (21) @(negedge sys_clk);
    resetn = 1'h1;
    rc(5'h04, 8'h00);
    h.wr(5'h05, 8'hff);
    rc(5'h05, 8'h00);
    rc(5'h06, 8'h00);
    rc(5'h1f, 8'h00);
    h.wr(5'h04, 8'hff);
    rc(5'h04, 8'hfc);
    $display("T1 done");
    r = 8'h14;
    for (int k = 0; k < 12; k++) begin
      r = lfsr(r);
      {driver_fault_in, line_code_violation, excess_zeros, zero_subst_en, all_ones_in} = r[4:0];
      fifo_wr_ptr = {r[1:0], r[7:4]};
      fifo_rd_ptr = fifo_wr_ptr + {{3{r[7]}}, r[7:5]};
      d = (fifo_wr_ptr - fifo_rd_ptr) & 63;
      rc(5'h05, {1'h0, r[4], d <= 3 || d >= 61, r[3] | r[2] & r[1], 1'h0, r[0], 2'h0});
    end
    $display("T2 done");
    quiet();
    h.wr(5'h04, 8'hc0);
    h.rd(5'h06, v);
    driver_fault_in = 1'h1;
    repeat (4) @(negedge sys_clk);
    chk({7'h0, int_n}, 8'h00);
    rc(5'h06, 8'h40);
    chk({7'h0, int_n}, 8'h01);
    driver_fault_in = 1'h0;
    repeat (4) @(negedge sys_clk);
    chk({7'h0, int_n}, 8'h00);
    h.wr(5'h04, 8'h40);
    chk({7'h0, int_n}, 8'h01);
    rc(5'h06, 8'h40);
    h.wr(5'h04, 8'h84);
    all_ones_in = 1'h1;
    repeat (4) @(negedge sys_clk);
    rc(5'h06, 8'h04);
    $display("T3 done");
    h.wr(5'h04, 8'h88);
    loop_code_mode_lo = 1'h1;
    feed(3, 60);
    rc(5'h05, 8'h0c);
    rc(5'h06, 8'h08);
    feed(1000, 4);
    rc(5'h05, 8'h04);
    feed(3, 60);
    loop_code_mode_hi = 1'h1;
    rc(5'h05, 8'h04);
    h.rd(5'h06, v);
    feed(5, 60);
    chk({7'h0, remote_loopback}, 8'h01);
    rc(5'h06, 8'h08);
    feed(1000, 30);
    rc(5'h05, 8'h0c);
    feed(3, 60);
    chk({7'h0, remote_loopback}, 8'h00);
    rc(5'h04, 8'h80);
    $display("T4 done");
    tally_and_finish();
  end
endmodule // test_line_alarm_status_loop_code
bind lasl_alarm_status lasl_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.sys_clk, .resetn, .reg_rd,
  .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .driver_fault_in, .all_ones_in, .loop_code_mode_hi,
  .loop_code_mode_lo, .remote_loopback, .int_n);
`default_nettype wire
